// *** shared/fetch_defines.svh ***
`ifndef FETCH_DEFINES_SVH
`define FETCH_DEFINES_SVH

// register offsets, byte addresses of 32-bit words
`define REG_CTRL      8'h00
`define REG_BASE_U    8'h04
`define REG_BASE_L    8'h08
`define REG_FRAME_CFG 8'h0C
`define REG_FIFO_CFG  8'h10
`define REG_STATUS    8'h14

// field layout and reset values
`define CTRL_W        9
`define CTRL_RESET    9'h000
`define FRAME_W       23
`define BURST_LSB     24
`define THRESH_W      10
`define THRESH_RESET  10'h1DD
`define ST_LVL_U      0
`define ST_LVL_L      10
`define ST_EOF        20
`define ST_BUSY       22

// fifo and burst sizing
`define FIFO_WORDS    10'h200
`define INCR_MAX      5'h10
`define WORD_BYTES    32'h4

// datapath latency and spacing, core clock cycles
`define LAT_TFT       5'h09
`define CPD_TFT       5'h01
`define LAT_M_S4      5'h0D
`define CPD_M_S4      5'h04
`define LAT_M_8       5'h11
`define CPD_M_8       5'h08
`define LAT_M_D16     5'h19
`define CPD_M_D16     5'h10
`define LAT_C_S4      5'h0B
`define CPD_C_S4      5'h02
`define LAT_C_S8      5'h0C
`define CPD_C_S8      5'h03
`define LAT_C_D8      5'h0E
`define CPD_C_D8      5'h04
`define LAT_C_D16     5'h0F
`define CPD_C_D16     5'h06

`endif

// *** shared/fetch_pkg.sv ***
package fetch_pkg;
  typedef logic [31:0] word_t;
  typedef logic [9:0]  level_t;
  typedef enum logic [1:0] {
    PANEL_TFT   = 2'b00,
    PANEL_MONO  = 2'b01,
    PANEL_COLOR = 2'b10
  } panel_e;
  typedef enum logic [1:0] {
    BURST_INCR   = 2'b00,
    BURST_INCR4  = 2'b01,
    BURST_INCR8  = 2'b10,
    BURST_INCR16 = 2'b11
  } burst_e;
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_ADDR = 2'b01,
    FETCH_DATA = 2'b10
  } fetch_state_e;
  typedef struct packed {
    logic [2:0] bpp;
    logic [1:0] width;
    panel_e     ptype;
    logic       dual;
    logic       enable;
  } cfg_s;
  typedef struct packed {
    logic       valid;
    word_t      addr;
    burst_e     burst;
    logic [4:0] beats;
  } mem_req_s;
  typedef struct packed {
    logic [4:0] latency;
    logic [4:0] spacing;
  } pace_s;
endpackage

// *** rtl/pixel_fifo_pair.sv ***
`timescale 1ns/1ps
`include "fetch_defines.svh"
module pixel_fifo_pair (
  input  logic                clock,
  input  logic                rst_n,
  input  logic                dual,
  input  logic                flush,
  input  logic [1:0]          push,
  input  fetch_pkg::word_t    push_data,
  input  logic [1:0]          pop,
  output fetch_pkg::word_t    rdata [2],
  output fetch_pkg::level_t   level [2],
  output logic [1:0]          full,
  output logic [1:0]          empty
);
  import fetch_pkg::*;

  word_t      mem_ff [`FIFO_WORDS];
  logic [8:0] waddr [2];
  level_t     cap;
  logic [8:0] wsel;

  assign cap  = dual ? level_t'(`FIFO_WORDS >> 1) : `FIFO_WORDS;
  assign wsel = push[1] ? waddr[1] : waddr[0];

  // one shared write port: pushes never coincide
  always_ff @(posedge clock) begin
    if (|push) mem_ff[wsel] <= push_data;
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_q
      logic [8:0] wptr_ff, rptr_ff;
      level_t     level_ff;
      // dual scan splits the memory in halves, single uses all of it
      assign waddr[i] = dual ? {1'(i), wptr_ff[7:0]} : wptr_ff;
      assign rdata[i] = mem_ff[dual ? {1'(i), rptr_ff[7:0]} : rptr_ff];
      assign level[i] = level_ff;
      assign full[i]  = level_ff >= cap;
      assign empty[i] = level_ff == '0;
      always_ff @(posedge clock) begin
        if (!rst_n || flush) begin
          wptr_ff  <= '0;
          rptr_ff  <= '0;
          level_ff <= '0;
        end else begin
          if (push[i]) wptr_ff <= wptr_ff + 9'h1;
          if (pop[i]) rptr_ff <= rptr_ff + 9'h1;
          level_ff <= level_ff + level_t'(push[i]) - level_t'(pop[i]);
        end
      end
      AST_NO_PUSH_FULL: assert property (@(posedge clock) disable iff (!rst_n) // [RL24]
        push[i] |-> !full[i]) else $error("push into a full fifo");
    end
  endgenerate
endmodule // pixel_fifo_pair

// *** rtl/display_fetch_dma_datapath.sv ***
`timescale 1ns/1ps
`include "fetch_defines.svh"
// How it works
// [RL1] configuration is written only over the register port, whole words only
// [RL2] bursts are incrementing, undefined length or 4, 8, 16 beats per field
// [RL3] upper channel tracks base address, words left, and flags frame end
// [RL4] frame restart reloads words left with frame size and address with base
// [RL5] software sets frame size as row words times rows, over 32, rounded up
// [RL6] row word count is rounded up: add 31 then divide by 32
// [RL7] software rewrites frame size whenever the 2D window moves
// [RL8] lower channel mirrors upper but runs only for lower panel in dual scan
// [RL9] control turns core fetch requests into requests for one channel
// [RL10] fifo input is one shared data bus with two push strobes
// [RL11] output is 24 bits, use set by panel type, scan and bus width
// [RL12] each datum is requested by the timing generator's data request
// [RL13] active matrix: first datum 9 cycles after its request
// [RL14] active matrix: a new datum can follow every cycle
// [RL15] mono passive latency/spacing: s4 13/4, 8-bit 17/8, d16 25/16
// [RL16] color passive latency/spacing: s4 11/2, s8 12/3, d8 14/4, d16 15/6
// [RL17] two fifos in dual scan, one combined fifo in single scan
// [RL18] a fetch is requested while a fifo holds fewer words than threshold
// [RL19] software sets threshold to 512 minus twice burst words plus 3
// [RL20] fifo capacity 512 words single, half the memory per fifo in dual
// [RL21] pixels stream to the panel bus paced by dot clock, enable and syncs
// [RL22] datapath chain: fifo, serializer, palette, dithering, shifter; the code has fifo, serializer and output mapping only, no palette or dithering
// [RL23] serializer unpacks words into 1 to 24 bit pixels by pixel size
// [RL24] never push into a full fifo; bursts wait until space is free
module display_fetch_dma_datapath (
  input  logic                clock,
  input  logic                rst_n,
  input  logic [7:0]          reg_addr,
  input  fetch_pkg::word_t    reg_wdata,
  input  logic                reg_write,
  input  logic                reg_read,
  output fetch_pkg::word_t    reg_rdata,
  output fetch_pkg::mem_req_s mem_req,
  input  logic                mem_grant,
  input  logic                mem_rvalid,
  input  fetch_pkg::word_t    mem_rdata,
  input  logic                new_frame,
  input  logic                data_req,
  input  logic                line_sync_in,
  input  logic                frame_sync_in,
  output logic [23:0]         panel_data_bus,
  output logic                data_enable_out,
  output logic                dot_clock_out,
  output logic                horiz_sync_out,
  output logic                vert_sync_out,
  output logic [1:0]          frame_end_out
);
  import fetch_pkg::*;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  cfg_s                cfg_ff;
  word_t               base_ff [2];
  logic [`FRAME_W-1:0] frame_size_ff;
  burst_e              burst_ff;
  level_t              thresh_ff;
  word_t               rdata_ff;
  word_t               rd_mux;
  word_t               status_word;
  logic                state_busy;

  // register port: no byte lanes, every write is a full word [RL1]
  wire wr_ctrl  = reg_write && reg_addr == `REG_CTRL;
  wire wr_basu  = reg_write && reg_addr == `REG_BASE_U;
  wire wr_basl  = reg_write && reg_addr == `REG_BASE_L;
  wire wr_frame = reg_write && reg_addr == `REG_FRAME_CFG;
  wire wr_fifo  = reg_write && reg_addr == `REG_FIFO_CFG;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_ff        <= cfg_s'(`CTRL_RESET);
      base_ff[0]    <= 32'h0;
      base_ff[1]    <= 32'h0;
      frame_size_ff <= '0;
      burst_ff      <= BURST_INCR;
      thresh_ff     <= `THRESH_RESET;
      rdata_ff      <= 32'h0;
    end else begin
      if (wr_ctrl) cfg_ff <= cfg_s'(reg_wdata[`CTRL_W-1:0]);
      if (wr_basu) base_ff[0] <= reg_wdata;
      if (wr_basl) base_ff[1] <= reg_wdata;
      if (wr_frame) frame_size_ff <= reg_wdata[`FRAME_W-1:0];
      if (wr_frame) burst_ff <= burst_e'(reg_wdata[`BURST_LSB+:2]);
      if (wr_fifo) thresh_ff <= reg_wdata[`THRESH_W-1:0];
      rdata_ff <= reg_read ? rd_mux : 32'h0;
    end
  end

  // fetch side: two channels, one bus master
  logic [`FRAME_W-1:0] rem [2];
  word_t               addr [2];
  logic [1:0]          eof;
  logic [1:0]          need;
  logic [1:0]          fit;
  logic [1:0]          tail;
  logic [1:0]          push;
  logic [1:0]          pop;
  logic [1:0]          full;
  logic [1:0]          empty;
  logic [4:0]          beats_for [2];
  logic [4:0]          fixed_beats;
  level_t              level [2];
  level_t              cap;
  word_t               fifo_rdata [2];

  assign cap = cfg_ff.dual ? level_t'(`FIFO_WORDS >> 1) : `FIFO_WORDS; // [RL20]
  assign fixed_beats = burst_ff == BURST_INCR4 ? 5'h04 :
                       burst_ff == BURST_INCR8 ? 5'h08 : `INCR_MAX;
  assign status_word = {9'h0, state_busy, eof, level[1], level[0]};
  assign rd_mux = reg_addr == `REG_CTRL      ? {23'h0, cfg_ff} :
                  reg_addr == `REG_BASE_U    ? base_ff[0] :
                  reg_addr == `REG_BASE_L    ? base_ff[1] :
                  reg_addr == `REG_FRAME_CFG ? {6'h0, burst_ff, 1'b0, frame_size_ff} :
                  reg_addr == `REG_FIFO_CFG  ? {22'h0, thresh_ff} :
                  reg_addr == `REG_STATUS    ? status_word : 32'h0;
  assign reg_rdata = rdata_ff;
  assign frame_end_out = eof;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_ch
      logic [`FRAME_W-1:0] rem_ff;
      word_t               addr_ff;
      logic                eof_ff;
      wire last_word = push[i] && rem_ff == `FRAME_W'(1);
      assign rem[i]  = rem_ff;
      assign addr[i] = addr_ff;
      assign eof[i]  = eof_ff;
      assign tail[i] = rem_ff < `FRAME_W'(fixed_beats);
      // the frame tail shorter than a fixed burst goes out as undefined length
      assign beats_for[i] = tail[i] ? 5'(rem_ff) : fixed_beats; // [RL2]
      // lower channel serves only the lower panel of a dual scan panel [RL8]
      assign need[i] = cfg_ff.enable && (i == 0 || cfg_ff.dual) && rem_ff != '0
                       && level[i] < thresh_ff; // [RL18]
      assign fit[i] = (cap - level[i]) >= level_t'(beats_for[i]); // [RL24]
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          rem_ff  <= '0;
          addr_ff <= 32'h0;
          eof_ff  <= 1'b0;
        end else if (new_frame) begin
          rem_ff  <= frame_size_ff; // [RL4]
          addr_ff <= base_ff[i]; // [RL4]
          eof_ff  <= last_word;
        end else if (push[i]) begin
          rem_ff  <= rem_ff - `FRAME_W'(1); // [RL3]
          addr_ff <= addr_ff + `WORD_BYTES;
          eof_ff  <= eof_ff | last_word; // [RL3]
        end
      end
    end
  endgenerate

  fetch_state_e state_ff;
  fetch_state_e nxt_state;
  mem_req_s     req_ff;
  logic         sel_ff;
  logic [4:0]   left_ff;
  logic         pick;
  logic         start;
  burst_e       start_burst;

  // upper panel first; lower is served when upper needs no fetch or its burst does not fit [RL9]
  assign pick  = !(need[0] && fit[0]);
  assign start = state_ff == FETCH_IDLE && |(need & fit); // [RL24]
  assign start_burst = tail[pick] ? BURST_INCR : burst_ff; // [RL2]
  assign push = {2{state_ff == FETCH_DATA && mem_rvalid}} & {sel_ff, !sel_ff}; // [RL10]
  assign state_busy = state_ff != FETCH_IDLE;
  assign mem_req = req_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FETCH_IDLE: if (start) nxt_state = FETCH_ADDR;
      FETCH_ADDR: if (mem_grant) nxt_state = FETCH_DATA;
      FETCH_DATA: if (mem_rvalid && left_ff == 5'h01) nxt_state = FETCH_IDLE;
      default:    nxt_state = FETCH_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= FETCH_IDLE;
      req_ff   <= '0;
      sel_ff   <= 1'b0;
      left_ff  <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        sel_ff  <= pick;
        left_ff <= beats_for[pick];
        req_ff  <= '{valid: 1'b1, addr: addr[pick], burst: start_burst,
                     beats: beats_for[pick]};
      end else begin
        if (state_ff == FETCH_ADDR && mem_grant) req_ff.valid <= 1'b0;
        if (|push) left_ff <= left_ff - 5'h01;
      end
    end
  end

  // input fifos: split in dual scan, combined in single scan [RL17] [RL22]
  pixel_fifo_pair u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .dual      (cfg_ff.dual),
    .flush     (new_frame),
    .push      (push),
    .push_data (mem_rdata),
    .pop       (pop),
    .rdata     (fifo_rdata),
    .level     (level),
    .full      (full),
    .empty     (empty)
  );

  // serializer lanes: lane 1 carries the lower panel in dual scan
  logic [23:0] pix [2];
  logic [1:0]  lane_valid;
  logic        pix_ok;
  logic        accept;
  generate
    for (i = 0; i < 2; i++) begin : g_lane
      word_t       word_ff;
      logic        valid_ff;
      logic [4:0]  idx_ff;
      logic [4:0]  last_idx;
      logic [4:0]  shift;
      logic [23:0] mask;
      wire lane_on = i == 0 || cfg_ff.dual;
      // 24 bpp is the unpacked layout only: one pixel per word
      assign last_idx = 5'h1F >> cfg_ff.bpp; // [RL23]
      assign shift = 5'(idx_ff << cfg_ff.bpp);
      assign mask = cfg_ff.bpp < 3'h5 ?
                    24'((32'h1 << (32'h1 << cfg_ff.bpp)) - 32'h1) : 24'hFFFFFF;
      assign pix[i] = 24'(word_ff >> shift) & mask; // [RL23]
      // refill on the last pixel, so one word per cycle can stream [RL14]
      assign pop[i] = lane_on && (!valid_ff || (accept && idx_ff == last_idx))
                      && !empty[i] && !new_frame;
      assign lane_valid[i] = valid_ff;
      always_ff @(posedge clock) begin
        if (!rst_n || new_frame) begin
          word_ff  <= 32'h0;
          valid_ff <= 1'b0;
          idx_ff   <= 5'h00;
        end else if (pop[i]) begin
          word_ff  <= fifo_rdata[i];
          valid_ff <= 1'b1;
          idx_ff   <= 5'h00;
        end else if (accept && lane_on) begin
          valid_ff <= idx_ff != last_idx;
          idx_ff   <= idx_ff + 5'h01;
        end
      end
    end
  endgenerate

  // output bus use by panel type, scan and width [RL11]
  logic [4:0]  wbits;
  logic [23:0] wmask;
  logic [23:0] hmask;
  logic [23:0] mapped;
  assign wbits = cfg_ff.width == 2'h0 ? 5'h04 : cfg_ff.width == 2'h1 ? 5'h08 :
                 cfg_ff.width == 2'h2 ? 5'h10 : 5'h18;
  assign wmask = 24'((32'h1 << wbits) - 32'h1);
  assign hmask = 24'((32'h1 << (wbits >> 1)) - 32'h1);
  assign mapped = cfg_ff.ptype == PANEL_TFT ? pix[0] :
                  !cfg_ff.dual ? pix[0] & wmask :
                  ((pix[0] & hmask) | ((pix[1] & hmask) << (wbits >> 1))) & wmask;

  pace_s pace;
  always_comb begin
    pace = '{latency: `LAT_TFT, spacing: `CPD_TFT}; // [RL13] [RL14]
    case ({cfg_ff.ptype, cfg_ff.dual, cfg_ff.width})
      {PANEL_MONO, 1'b0, 2'h0}:  pace = '{`LAT_M_S4, `CPD_M_S4}; // [RL15]
      {PANEL_MONO, 1'b0, 2'h1},
      {PANEL_MONO, 1'b1, 2'h1}:  pace = '{`LAT_M_8, `CPD_M_8}; // [RL15]
      {PANEL_MONO, 1'b1, 2'h2}:  pace = '{`LAT_M_D16, `CPD_M_D16}; // [RL15]
      {PANEL_COLOR, 1'b0, 2'h0}: pace = '{`LAT_C_S4, `CPD_C_S4}; // [RL16]
      {PANEL_COLOR, 1'b0, 2'h1}: pace = '{`LAT_C_S8, `CPD_C_S8}; // [RL16]
      {PANEL_COLOR, 1'b1, 2'h1}: pace = '{`LAT_C_D8, `CPD_C_D8}; // [RL16]
      {PANEL_COLOR, 1'b1, 2'h2}: pace = '{`LAT_C_D16, `CPD_C_D16}; // [RL16]
      default: pace = '{`LAT_TFT, `CPD_TFT};
    endcase
  end

  // pacing: a request loads the delay; the datum lands on the pins after it
  logic [4:0]  cnt_ff;
  logic        first_ff;
  logic [23:0] hold_ff;
  logic [4:0]  dly;
  logic        nxt_emit;
  assign pix_ok = lane_valid[0] && (!cfg_ff.dual || lane_valid[1]);
  assign accept = data_req && cfg_ff.enable && pix_ok && cnt_ff <= 5'h01; // [RL12]
  assign dly = first_ff ? pace.latency : pace.spacing;
  assign nxt_emit = cnt_ff == 5'h02 || (accept && dly == 5'h01);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_ff          <= 5'h00;
      first_ff        <= 1'b1;
      hold_ff         <= 24'h0;
      panel_data_bus  <= 24'h0;
      data_enable_out <= 1'b0;
      dot_clock_out   <= 1'b0;
      horiz_sync_out  <= 1'b0;
      vert_sync_out   <= 1'b0;
    end else begin
      cnt_ff   <= accept ? dly : cnt_ff - 5'(cnt_ff != 5'h00);
      first_ff <= new_frame || (first_ff && !accept);
      if (accept) hold_ff <= mapped;
      if (nxt_emit) panel_data_bus <= (accept && dly == 5'h01) ? mapped : hold_ff; // [RL21]
      data_enable_out <= nxt_emit; // [RL21]
      dot_clock_out   <= dot_clock_out ^ nxt_emit;
      horiz_sync_out  <= line_sync_in;
      vert_sync_out   <= frame_sync_in;
    end
  end

  sequence s_first_req;
    accept && first_ff;
  endsequence
  wire is_tft  = cfg_ff.ptype == PANEL_TFT;
  wire m_s4    = cfg_ff.ptype == PANEL_MONO && !cfg_ff.dual && cfg_ff.width == 2'h0;
  wire c_s4    = cfg_ff.ptype == PANEL_COLOR && !cfg_ff.dual && cfg_ff.width == 2'h0;

  AST_FIXED_BEATS: assert property ($rose(req_ff.valid) && req_ff.burst != BURST_INCR // [RL2]
    |-> req_ff.beats == (req_ff.burst == BURST_INCR4 ? 5'h04 :
                         req_ff.burst == BURST_INCR8 ? 5'h08 : 5'h10))
    else $error("fixed burst with wrong beat count");
  AST_RELOAD: assert property (new_frame |=> rem[0] == $past(frame_size_ff) // [RL4]
    && addr[0] == $past(base_ff[0])) else $error("channel not reloaded at frame start");
  AST_EOF: assert property (push[0] && rem[0] == `FRAME_W'(1) |=> eof[0]) // [RL3]
    else $error("end of frame not raised");
  AST_LOWER_IDLE: assert property (!cfg_ff.dual |-> !push[1] && !pop[1]) // [RL8]
    else $error("lower fifo used in single scan");
  AST_FETCH_REQ: assert property (state_ff == FETCH_IDLE && need[0] && fit[0] // [RL9]
    |=> req_ff.valid && !sel_ff ##0 state_ff == FETCH_ADDR)
    else $error("upper fetch request not issued");
  AST_TFT_LAT: assert property (s_first_req ##0 is_tft // [RL13]
    |=> !data_enable_out [*8] ##1 data_enable_out) else $error("tft latency not 9");
  AST_TFT_RATE: assert property (accept && !first_ff && is_tft |=> data_enable_out) // [RL14]
    else $error("tft datum not one cycle after request");
  AST_MONO_SPACING: assert property (data_enable_out && m_s4 && !$changed(cfg_ff) // [RL15]
    |=> !data_enable_out [*3]) else $error("mono 4-bit spacing below 4");
  AST_COLOR_LAT: assert property (s_first_req ##0 c_s4 |-> ##11 data_enable_out) // [RL16]
    else $error("color 4-bit latency not 11");
endmodule // display_fetch_dma_datapath

// *** testbench/frame_memory_model.sv ***
`timescale 1ns/1ps
module frame_memory_model (
  input  logic                clock,
  input  logic                rst_n,
  input  logic                slow,
  input  fetch_pkg::mem_req_s mem_req,
  output logic                mem_grant,
  output logic                mem_rvalid,
  output fetch_pkg::word_t    mem_rdata
);
  import fetch_pkg::*;
  logic       busy_ff;
  logic       gap_ff;
  logic [1:0] wait_ff;
  logic [4:0] left_ff;
  word_t      addr_ff;

  // slow mode delays the grant and spaces the beats; the bus never sees stale data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_grant  <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 32'hA5A5A5A5;
      busy_ff    <= 1'b0;
      gap_ff     <= 1'b0;
      wait_ff    <= 2'h0;
      left_ff    <= 5'h00;
      addr_ff    <= 32'h00000000;
    end else begin
      mem_grant  <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      gap_ff     <= slow & ~gap_ff;
      if (!busy_ff && mem_req.valid && !mem_grant) begin
        if (!slow || wait_ff == 2'h3) begin
          mem_grant <= 1'b1;
          busy_ff   <= 1'b1;
          addr_ff   <= mem_req.addr;
          left_ff   <= mem_req.beats;
          wait_ff   <= 2'h0;
        end else begin
          wait_ff <= wait_ff + 2'h1;
        end
      end else if (busy_ff && !gap_ff && left_ff != 5'h00) begin
        // data word equals its own byte address, so the bench can predict pixels
        mem_rvalid <= 1'b1;
        mem_rdata  <= addr_ff;
        addr_ff    <= addr_ff + 32'h4;
        left_ff    <= left_ff - 5'h01;
        busy_ff    <= (left_ff != 5'h01);
      end
    end
  end
endmodule // frame_memory_model

// *** testbench/display_fetch_dma_datapath_tb.sv ***
`timescale 1ns/1ps
`include "fetch_defines.svh"
module display_fetch_dma_datapath_tb;
  import fetch_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  word_t       reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  word_t       reg_rdata;
  mem_req_s    mem_req;
  logic        mem_grant;
  logic        mem_rvalid;
  word_t       mem_rdata;
  logic        slow = 1'b0;
  logic        new_frame = 1'b0;
  logic        data_req = 1'b0;
  logic        line_sync_in = 1'b0;
  logic        frame_sync_in = 1'b0;
  logic [23:0] panel_data_bus;
  logic        data_enable_out;
  logic        dot_clock_out;
  logic        horiz_sync_out;
  logic        vert_sync_out;
  logic [1:0]  frame_end_out;
  int          failures = 0;
  int          check_count = 0;

  always #12.5 clock = ~clock;

  display_fetch_dma_datapath dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_grant(mem_grant), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .new_frame(new_frame), .data_req(data_req), .line_sync_in(line_sync_in),
    .frame_sync_in(frame_sync_in), .panel_data_bus(panel_data_bus),
    .data_enable_out(data_enable_out), .dot_clock_out(dot_clock_out),
    .horiz_sync_out(horiz_sync_out), .vert_sync_out(vert_sync_out),
    .frame_end_out(frame_end_out));

  frame_memory_model mem_u (.clock(clock), .rst_n(rst_n), .slow(slow), .mem_req(mem_req),
    .mem_grant(mem_grant), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  task automatic check_word(input string name, input word_t exp, input word_t got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_cyc(input string name, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input word_t d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output word_t d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pulse_frame();
    @(posedge clock);
    new_frame <= 1'b1;
    @(posedge clock);
    new_frame <= 1'b0;
  endtask

  // waits for the granted cycle of the next request and returns its fields
  task automatic next_request(output mem_req_s r);
    r = '0;
    for (int i = 0; i < 200; i++) begin
      @(posedge clock);
      #1;
      if (mem_req.valid && mem_grant) begin
        r = mem_req;
        break;
      end
    end
  endtask

  // word count a driver programs: row words rounded up, then over the frame
  function automatic word_t frame_size(input int px_m1, input int bpp, input int off,
                                       input int rows_m1);
    int row_words;
    row_words = ((px_m1 + 1) * bpp + off + 31) / 32;
    return word_t'((row_words * (rows_m1 + 1) + 31) / 32);
  endfunction

  task automatic reg_scenario();
    word_t d;
    reg_rd(`REG_CTRL, d);
    check_word("ctrl reset", 32'h0, d);
    reg_rd(`REG_FIFO_CFG, d);
    check_word("threshold reset", 32'h1DD, d);
    reg_wr(`REG_BASE_U, 32'h1000);
    reg_rd(`REG_BASE_U, d);
    check_word("upper base", 32'h1000, d);
    reg_wr(`REG_STATUS, 32'hFFFFFFFF);
    reg_rd(`REG_STATUS, d);
    check_word("status after write", 32'h0, d);
    reg_wr(8'h18, 32'h5A5A5A5A);
    reg_rd(8'h18, d);
    check_word("unmapped read", 32'h0, d);
    @(posedge clock);
    line_sync_in <= 1'b1;
    @(posedge clock);
    line_sync_in  <= 1'b0;
    frame_sync_in <= 1'b1;
    #1;
    check_word("line sync", 32'h1, {31'h0, horiz_sync_out});
    @(posedge clock);
    frame_sync_in <= 1'b0;
    #1;
    check_word("frame sync", 32'h1, {31'h0, vert_sync_out});
  endtask

  task automatic fetch_scenario();
    mem_req_s r;
    word_t    d;
    reg_wr(`REG_FRAME_CFG, 32'h0200_0014);
    reg_wr(`REG_CTRL, 32'h171);
    pulse_frame();
    for (int i = 0; i < 3; i++) begin
      next_request(r);
      check_word("burst addr", 32'h1000 + 32'h20 * i, r.addr);
      check_word("burst kind", (i < 2) ? 32'h2 : 32'h0, {30'h0, r.burst});
      check_word("burst beats", (i < 2) ? 32'h8 : 32'h4, {27'h0, r.beats});
    end
    repeat (30) @(posedge clock);
    #1;
    check_word("upper eof", 32'h1, {30'h0, frame_end_out});
    reg_rd(`REG_STATUS, d);
    // one word already sits in the serializer lane
    check_word("fifo level", 32'h0010_0013, d);
    slow = 1'b1;
    reg_wr(`REG_FRAME_CFG, 32'h0100_0014);
    pulse_frame();
    next_request(r);
    check_word("reload addr", 32'h1000, r.addr);
    check_word("reload kind", 32'h1, {30'h0, r.burst});
    check_word("eof cleared", 32'h0, {30'h0, frame_end_out});
    repeat (120) @(posedge clock);
    slow = 1'b0;
  endtask

  task automatic pace_scenario();
    logic [8:0] ctrl [9] = '{9'h171, 9'h0C5, 9'h0D5, 9'h0D7, 9'h0E7,
                             9'h0C9, 9'h0D9, 9'h0DB, 9'h0EB};
    int lat [9] = '{9, 13, 17, 17, 25, 11, 12, 14, 15};
    int spc [9] = '{1, 4, 8, 8, 16, 2, 3, 4, 6};
    int n;
    word_t d;
    logic dk;
    reg_wr(`REG_BASE_L, 32'h2000);
    reg_wr(`REG_FIFO_CFG, 32'h1DD);
    reg_wr(`REG_FRAME_CFG, 32'h0300_0000 | frame_size(63, 32, 0, 31));
    for (int k = 0; k < 9; k++) begin
      if (k == 5) begin
        reg_wr(`REG_FRAME_CFG, 32'h0300_0000 | frame_size(63, 32, 16, 31));
        reg_rd(`REG_FRAME_CFG, d);
        check_word("moved frame size", 32'h0300_0041, d);
      end
      reg_wr(`REG_CTRL, {23'h0, ctrl[k]});
      pulse_frame();
      repeat (250) @(posedge clock);
      #1;
      check_word("eof flags", {30'h0, ctrl[k][1], 1'b1}, {30'h0, frame_end_out});
      @(posedge clock);
      data_req <= 1'b1;
      dk = dot_clock_out;
      n = 0;
      do begin
        @(posedge clock);
        #1;
        n++;
      end while (!data_enable_out && n < 40);
      check_cyc("first latency", lat[k], n);
      check_word("dot clock", {31'h0, !dk}, {31'h0, dot_clock_out});
      if (k == 0) begin
        check_word("first pixel", 32'h1000, {8'h0, panel_data_bus});
      end
      n = 0;
      do begin
        @(posedge clock);
        #1;
        n++;
      end while (!data_enable_out && n < 40);
      check_cyc("spacing", spc[k], n);
      @(posedge clock);
      data_req <= 1'b0;
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    reg_scenario();
    fetch_scenario();
    pace_scenario();
    give_verdict();
  end

  // whole run needs about 2800 cycles; seven times that means a hang
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    give_verdict();
  end
endmodule // display_fetch_dma_datapath_tb
